// File: common/gsd_regs.svh
`ifndef GSD_REGS_SVH
`define GSD_REGS_SVH

// --------------------------------------------------------------
// graphics configuration register fields
// --------------------------------------------------------------
`define GSD_GCR_RESET 8'h00
`define GSD_GCR_SP_HI 3
`define GSD_GCR_SP_LO 2
`define GSD_GCR_GX_HI 1
`define GSD_GCR_GX_LO 0
`define GSD_GCR_USED_MASK 8'h0f

// --------------------------------------------------------------
// space layout, offsets above the space base
// --------------------------------------------------------------
`define GSD_BASE_SHIFT 30
`define GSD_CTRL_LO 16'h8000
`define GSD_CTRL_SIZE 16'h8000
`define GSD_GP_LO 16'h8100
`define GSD_DC_LO 16'h8300
`define GSD_MC_LO 16'h8400
`define GSD_PM_LO 16'h8500
`define GSD_PM_HI 16'h8fff
`define GSD_GMEM_LO 24'h800000
`define GSD_GMEM_SIZE 24'h400000

// --------------------------------------------------------------
// scratchpad sizes in 16-byte lines of set 0
// --------------------------------------------------------------
`define GSD_SET0_LINES 9'h100
`define GSD_SP_LINES_2K 9'h080
`define GSD_SP_LINES_3K 9'h0c0
`define GSD_SP_LINES_4K 9'h100

// --------------------------------------------------------------
// internal register addresses and fields
// --------------------------------------------------------------
`define GSD_CREG_START0 32'hffffff0c
`define GSD_CREG_START1 32'hffffff1c
`define GSD_CREG_CURSOR0 32'hffffff2c
`define GSD_CREG_CURSOR1 32'hffffff3c
`define GSD_IDX_HI 11
`define GSD_IDX_LO 4
`define GSD_BYTE_HI 3

`endif

// File: common/gsd_pkg.sv
package gsd_pkg;

   // decoded target of a space access
   typedef enum logic [2:0] {
      GSD_RGN_NONE,
      GSD_RGN_SCRATCH,
      GSD_RGN_BIU,
      GSD_RGN_GP,
      GSD_RGN_DC,
      GSD_RGN_MC,
      GSD_RGN_PM,
      GSD_RGN_GMEM
   } gsd_rgn_t;

   typedef enum logic [1:0] {GSD_IDLE, GSD_WB, GSD_FILL, GSD_REPLAY} gsd_st_t;

   typedef struct packed {
      logic valid;
      gsd_rgn_t rgn;
      logic [23:0] off;
   } gsd_dec_t;

   typedef struct packed {
      logic sel;
      logic wr;
      logic [31:0] wdata;
   } gsd_blt_req_t;

   typedef struct packed {
      logic req;
      logic we;
      logic [7:0] idx;
      logic [3:0] wmask;
      logic [127:0] wdata;
   } gsd_l1_req_t;

   typedef struct packed {
      logic we;
      logic re;
      logic [31:0] addr;
      logic [31:0] wdata;
   } gsd_creg_req_t;

   typedef struct packed {
      logic [11:0] start;
      logic [7:0] cursor;
      logic [1:0] slot;
   } gsd_agen_t;

endpackage

// File: logic/gsd_blt_agen.sv
`timescale 1ns/100ps
`default_nettype none
`include "gsd_regs.svh"

module gsd_blt_agen (
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // register writes
   input wire logic wr_start_i,
   input wire logic wr_cursor_i,
   input wire logic [11:0] wdata_i,
   // stream control
   input wire logic adv_i,
   input wire logic reload_i,
   // state
   output gsd_pkg::gsd_agen_t state_o
);
   import gsd_pkg::*;

   gsd_agen_t q, d;

   always_comb begin
      d = q;
      if (wr_start_i) begin
         d.start = wdata_i;
      end
      if (adv_i) begin
         d.slot = q.slot + 2'h1;
         if (q.slot == 2'h3) begin
            d.cursor = q.cursor + 8'h01;
         end
      end
      if (wr_cursor_i) begin
         d.cursor = wdata_i[`GSD_IDX_HI:`GSD_IDX_LO];
         d.slot = 2'h0;
      end
      if (reload_i) begin
         d.cursor = q.start[`GSD_IDX_HI:`GSD_IDX_LO];
         d.slot = q.start[`GSD_BYTE_HI:2];
      end
   end

   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign state_o = q;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   chk_reload_copy: assert property (reload_i |=> q.cursor == $past(q.start[11:4]))
      else $error("cursor not reloaded from start");
   chk_line_step: assert property (adv_i && !reload_i && !wr_cursor_i && q.slot == 2'h3
      |=> q.cursor == $past(q.cursor) + 8'h01 && q.slot == 2'h0)
      else $error("cursor did not step at line end");

endmodule // gsd_blt_agen
`default_nettype wire

// File: logic/gsd_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "gsd_regs.svh"

// Summary of operation
// - decode 32 KB control area at 8000h
// - 8000h-80FFh goes to bus interface
// - 8100h-82FFh goes to graphics pipeline
// - 8300h-83FFh goes to display controller
// - 8400h-84FFh goes to memory controller
// - 8500h-8FFFh goes to power management
// - undefined control locations complete without error
// - graphics memory is 4 MB at 800000h
// - scratchpad from set 0 shrinks cache
// - scratchpad lines stay valid, never flushed
// - nonzero size locks the scratchpad tags
// - 16-byte line buffer serves BLT traffic
// - 32-bit requests addressed from start and cursor
// - cursor advances after the access to the last word of a line
// - reload copies start into cursor
// - start register locates buffer first byte
// - cursor register holds current line
// - start holds index and byte, cursor index
// - size field 00/01/10/11 = 0/2/3/4 KB
// - base field 00 off, else 40/80/C0 000000h
module gsd_top (
   // clock and reset
   input wire logic clk_i,
   input wire logic resetn_i,
   // graphics configuration register
   input wire logic cfg_we_i,
   input wire logic [7:0] cfg_wdata_i,
   output logic [7:0] cfg_rdata_o,
   output logic gfx_insn_en_o,
   output logic sp_tag_lock_o,
   output logic [8:0] sp_lines_o,
   output logic [8:0] cache_lines_o,
   // memory space decode
   input wire logic mem_valid_i,
   input wire logic [31:0] mem_addr_i,
   output gsd_pkg::gsd_dec_t dec_o,
   // set 0 line protection query
   input wire logic [7:0] l1_line_i,
   output logic l1_keep_o,
   // internal register access
   input wire gsd_pkg::gsd_creg_req_t creg_i,
   output logic [31:0] creg_rdata_o,
   output logic creg_rvalid_o,
   // graphics pipeline blt stream
   input wire logic blt_valid_i,
   input wire gsd_pkg::gsd_blt_req_t blt_i,
   input wire logic [1:0] blt_reload_i,
   output logic blt_ready_o,
   output logic blt_ack_o,
   output logic [11:0] blt_addr_o,
   output logic blt_rvalid_o,
   output logic [31:0] blt_rdata_o,
   // l1 set 0 array port
   output gsd_pkg::gsd_l1_req_t l1_o,
   input wire logic l1_ack_i,
   input wire logic [127:0] l1_rdata_i
);
   import gsd_pkg::*;

   typedef struct packed {
      logic [7:0] graphics_config_reg;
      logic [8:0] sp_lines;
      logic [8:0] cache_lines;
      logic tag_lock;
      logic keep;
      gsd_dec_t dec;
      logic [31:0] creg_rdata;
      logic creg_rvalid;
      gsd_st_t st;
      gsd_blt_req_t pend;
      logic [7:0] lb_idx;
      logic lb_own;
      logic [3:0] lb_wvld;
      logic [3:0] lb_dirty;
      logic [127:0] lb_data;
      logic blt_ready;
      logic blt_ack;
      logic [11:0] blt_addr;
      logic blt_rvalid;
      logic [31:0] blt_rdata;
      gsd_l1_req_t l1;
   } gsd_state_t;

   gsd_state_t q, d;
   gsd_agen_t ag [2];
   logic [1:0] adv;
   logic in_space;
   logic take;
   logic line_hit;
   gsd_blt_req_t cur_req;
   gsd_agen_t cur;

   // --------------------------------------------------------------
   // blt buffer address generators
   // --------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_buf
         localparam logic [31:0] START_A = (gi == 0) ? `GSD_CREG_START0 : `GSD_CREG_START1;
         localparam logic [31:0] CURS_A = (gi == 0) ? `GSD_CREG_CURSOR0 : `GSD_CREG_CURSOR1;
         // written only through the special register port
         gsd_blt_agen u_agen (
            .clk_i(clk_i),
            .resetn_i(resetn_i),
            .wr_start_i(creg_i.we && creg_i.addr == START_A),
            .wr_cursor_i(creg_i.we && creg_i.addr == CURS_A),
            .wdata_i(creg_i.wdata[11:0]),
            .adv_i(adv[gi]),
            .reload_i(blt_reload_i[gi]),
            .state_o(ag[gi])
         );
      end
   endgenerate

   // --------------------------------------------------------------
   // next state
   // --------------------------------------------------------------
   always_comb begin
      d = q;
      adv = 2'b00;

      // configuration, reserved bits kept zero
      if (cfg_we_i) begin
         d.graphics_config_reg = cfg_wdata_i & `GSD_GCR_USED_MASK;
      end
      case (q.graphics_config_reg[`GSD_GCR_SP_HI:`GSD_GCR_SP_LO])
         2'h1: d.sp_lines = `GSD_SP_LINES_2K;
         2'h2: d.sp_lines = `GSD_SP_LINES_3K;
         2'h3: d.sp_lines = `GSD_SP_LINES_4K;
         default: d.sp_lines = 9'h000;
      endcase
      d.cache_lines = `GSD_SET0_LINES - q.sp_lines;
      d.tag_lock = q.sp_lines != 9'h000;
      // scratchpad occupies the top lines of set 0
      d.keep = q.tag_lock &&
         ({1'b0, l1_line_i} >= `GSD_SET0_LINES - q.sp_lines);

      // space decode, always answered the cycle after the access
      in_space = q.graphics_config_reg[`GSD_GCR_GX_HI:`GSD_GCR_GX_LO] != 2'h0 &&
         mem_addr_i[31:`GSD_BASE_SHIFT] == q.graphics_config_reg[`GSD_GCR_GX_HI:`GSD_GCR_GX_LO] &&
         mem_addr_i[29:24] == 6'h00;
      d.dec.valid = mem_valid_i;
      d.dec.off = mem_addr_i[23:0];
      // bits 22:16 are not decoded inside the control half
      if (!in_space) begin
         d.dec.rgn = GSD_RGN_NONE;
      end else if (mem_addr_i[23]) begin
         d.dec.rgn = mem_addr_i[22] ? GSD_RGN_NONE : GSD_RGN_GMEM;
      end else if (!mem_addr_i[15]) begin
         d.dec.rgn = GSD_RGN_SCRATCH;
      end else if (mem_addr_i[15:0] < `GSD_GP_LO) begin
         d.dec.rgn = GSD_RGN_BIU;
      end else if (mem_addr_i[15:0] < `GSD_DC_LO) begin
         d.dec.rgn = GSD_RGN_GP;
      end else if (mem_addr_i[15:0] < `GSD_MC_LO) begin
         d.dec.rgn = GSD_RGN_DC;
      end else if (mem_addr_i[15:0] < `GSD_PM_LO) begin
         d.dec.rgn = GSD_RGN_MC;
      end else if (mem_addr_i[15:0] <= `GSD_PM_HI) begin
         d.dec.rgn = GSD_RGN_PM;
      end else begin
         d.dec.rgn = GSD_RGN_NONE;
      end

      // internal register reads, reserved bits read zero
      d.creg_rvalid = creg_i.re;
      case (creg_i.addr)
         `GSD_CREG_START0: d.creg_rdata = {20'h0, ag[0].start};
         `GSD_CREG_START1: d.creg_rdata = {20'h0, ag[1].start};
         `GSD_CREG_CURSOR0: d.creg_rdata = {20'h0, ag[0].cursor, 4'h0};
         `GSD_CREG_CURSOR1: d.creg_rdata = {20'h0, ag[1].cursor, 4'h0};
         default: d.creg_rdata = 32'h0;
      endcase

      // blt stream through the line buffer
      d.blt_ack = 1'b0;
      d.blt_rvalid = 1'b0;
      // a missed request is parked in pend and replayed once the array answers
      take = (q.st == GSD_IDLE && blt_valid_i && q.blt_ready) || q.st == GSD_REPLAY;
      cur_req = (q.st == GSD_REPLAY) ? q.pend : blt_i;
      cur = ag[cur_req.sel];
      line_hit = q.lb_wvld != 4'h0 && q.lb_own == cur_req.sel && q.lb_idx == cur.cursor;
      if (take) begin
         d.pend = cur_req;
         if (cur_req.wr && (line_hit || q.lb_dirty == 4'h0)) begin
            if (!line_hit) begin
               d.lb_wvld = 4'h0;
               d.lb_dirty = 4'h0;
               d.lb_idx = cur.cursor;
               d.lb_own = cur_req.sel;
            end
            d.lb_data[{cur.slot, 5'h00} +: 32] = cur_req.wdata;
            d.lb_wvld[cur.slot] = 1'b1;
            d.lb_dirty[cur.slot] = 1'b1;
         end else if (!cur_req.wr && line_hit && q.lb_wvld[cur.slot]) begin
            d.blt_rdata = q.lb_data[{cur.slot, 5'h00} +: 32];
            d.blt_rvalid = 1'b1;
         end else if (q.lb_dirty != 4'h0) begin
            d.l1.req = 1'b1;
            d.l1.we = 1'b1;
            d.l1.idx = q.lb_idx;
            d.l1.wmask = q.lb_dirty;
            d.l1.wdata = q.lb_data;
            d.st = GSD_WB;
            d.blt_ready = 1'b0;
         end else begin
            d.l1.req = 1'b1;
            d.l1.we = 1'b0;
            d.l1.idx = cur.cursor;
            d.l1.wmask = 4'h0;
            d.st = GSD_FILL;
            d.blt_ready = 1'b0;
         end
         if (d.st == q.st && q.st == GSD_IDLE || q.st == GSD_REPLAY && d.st == GSD_REPLAY) begin
            adv[cur_req.sel] = 1'b1;
            d.blt_ack = 1'b1;
            d.blt_addr = {cur.cursor, cur.slot, 2'b00};
            d.st = GSD_IDLE;
            d.blt_ready = 1'b1;
         end
      end else if (q.st == GSD_WB && l1_ack_i) begin
         d.l1.req = 1'b0;
         d.lb_dirty = 4'h0;
         d.lb_wvld = 4'h0;
         d.st = GSD_REPLAY;
      end else if (q.st == GSD_FILL && l1_ack_i) begin
         d.l1.req = 1'b0;
         d.lb_data = l1_rdata_i;
         d.lb_wvld = 4'hf;
         d.lb_dirty = 4'h0;
         d.lb_idx = q.l1.idx;
         d.lb_own = q.pend.sel;
         d.st = GSD_REPLAY;
      end
   end

   // --------------------------------------------------------------
   // state register
   // --------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (!resetn_i) begin
         q <= '0;
         q.graphics_config_reg <= `GSD_GCR_RESET;
         q.cache_lines <= `GSD_SET0_LINES;
         // ready already while reset is held
         q.blt_ready <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign cfg_rdata_o = q.graphics_config_reg;
   assign gfx_insn_en_o = q.tag_lock;
   assign sp_tag_lock_o = q.tag_lock;
   assign sp_lines_o = q.sp_lines;
   assign cache_lines_o = q.cache_lines;
   assign dec_o = q.dec;
   assign l1_keep_o = q.keep;
   assign creg_rdata_o = q.creg_rdata;
   assign creg_rvalid_o = q.creg_rvalid;
   assign blt_ready_o = q.blt_ready;
   assign blt_ack_o = q.blt_ack;
   assign blt_addr_o = q.blt_addr;
   assign blt_rvalid_o = q.blt_rvalid;
   assign blt_rdata_o = q.blt_rdata;
   assign l1_o = q.l1;

   // --------------------------------------------------------------
   // checks
   // --------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   chk_ctrl_window: assert property (mem_valid_i && in_space && !mem_addr_i[23] &&
      mem_addr_i[15] |=> dec_o.rgn != GSD_RGN_SCRATCH && dec_o.rgn != GSD_RGN_GMEM)
      else $error("control area decoded as memory");
   chk_rgn_scratch: assert property (mem_valid_i && in_space && !mem_addr_i[23] &&
      !mem_addr_i[15] |=> dec_o.rgn == GSD_RGN_SCRATCH)
      else $error("scratchpad range misdecoded");
   chk_rgn_biu: assert property (mem_valid_i && in_space && !mem_addr_i[23] &&
      mem_addr_i[15:8] == 8'h80 |=> dec_o.rgn == GSD_RGN_BIU)
      else $error("bus interface range misdecoded");
   // the pipeline area spans two 256-location pages, not one aligned block
   chk_rgn_gp: assert property (mem_valid_i && in_space && !mem_addr_i[23] &&
      (mem_addr_i[15:8] == 8'h81 || mem_addr_i[15:8] == 8'h82) |=> dec_o.rgn == GSD_RGN_GP)
      else $error("graphics pipeline range misdecoded");
   chk_rgn_dc: assert property (mem_valid_i && in_space && !mem_addr_i[23] &&
      mem_addr_i[15:8] == 8'h83 |=> dec_o.rgn == GSD_RGN_DC)
      else $error("display range misdecoded");
   chk_rgn_mc: assert property (mem_valid_i && in_space && !mem_addr_i[23] &&
      mem_addr_i[15:8] == 8'h84 |=> dec_o.rgn == GSD_RGN_MC)
      else $error("memory controller range misdecoded");
   chk_rgn_pm: assert property (dec_o.valid && dec_o.rgn == GSD_RGN_PM |->
      dec_o.off[15:0] >= 16'h8500 && dec_o.off[15:0] <= 16'h8fff)
      else $error("power management range misdecoded");
   chk_undef_done: assert property (mem_valid_i |=> dec_o.valid)
      else $error("access not completed");
   chk_gmem_win: assert property (mem_valid_i && in_space && mem_addr_i[23:22] == 2'b10
      |=> dec_o.rgn == GSD_RGN_GMEM && dec_o.off[23] ##1 1)
      else $error("graphics memory misdecoded");
   chk_base_off: assert property (mem_valid_i && q.graphics_config_reg[1:0] == 2'h0 |=>
      dec_o.rgn == GSD_RGN_NONE)
      else $error("disabled space decoded");
   chk_size_lines: assert property (cfg_we_i && cfg_wdata_i[3:2] == 2'h2
      ##1 !cfg_we_i |=> sp_lines_o == 9'h0c0 ##1 cache_lines_o == 9'h040)
      else $error("3 KB size not applied");
   chk_tag_lock: assert property (cfg_we_i && cfg_wdata_i[3:2] != 2'h0
      ##1 !cfg_we_i [*2] |=> sp_tag_lock_o)
      else $error("tags not locked");
   chk_keep_line: assert property (sp_tag_lock_o && sp_lines_o == 9'h100 |=> l1_keep_o)
      else $error("scratchpad line not kept");
   chk_lbuf_hit: assert property (blt_rvalid_o |-> $past(!l1_o.req || l1_ack_i))
      else $error("read served while array busy");
   chk_busy_ready: assert property (q.st != GSD_IDLE |-> !blt_ready_o)
      else $error("request accepted while line buffer busy");
   chk_wb_mask: assert property (l1_o.req && l1_o.we |-> l1_o.wmask != 4'h0)
      else $error("write-back without dirty words");
   chk_read_pair: assert property (blt_rvalid_o |-> blt_ack_o)
      else $error("read data without acknowledge");
   chk_addr_form: assert property (q.st == GSD_IDLE && q.blt_ready && blt_valid_i &&
      !blt_i.wr && line_hit && q.lb_wvld[ag[blt_i.sel].slot] |=> blt_ack_o &&
      blt_addr_o == {$past(ag[blt_i.sel].cursor), $past(ag[blt_i.sel].slot), 2'b00})
      else $error("blt address not from cursor");
   chk_other_buf: assert property (adv == 2'b01 && blt_reload_i[1] == 1'b0 &&
      !creg_i.we |=> $stable(ag[1]))
      else $error("idle buffer disturbed");

   cov_read_hit: cover property (blt_rvalid_o && !$past(l1_o.req));
   cov_writeback: cover property (q.st == GSD_WB && l1_ack_i);
   cov_fill: cover property (q.st == GSD_FILL ##[1:8] blt_rvalid_o);
   cov_reload: cover property (blt_reload_i[0] && blt_reload_i[1]);

endmodule // gsd_top
`default_nettype wire

// File: test/gsd_l1_model.sv
`timescale 1ns/100ps
`default_nettype none

module gsd_l1_model (
   // clock
   input wire logic clk_i,
   // set 0 array port
   input wire gsd_pkg::gsd_l1_req_t l1_i,
   output logic l1_ack_o,
   output logic [127:0] l1_rdata_o
);
   import gsd_pkg::*;
   // ----------------------------------------
   // set 0 array
   // ----------------------------------------
   logic [127:0] mem_q [256];
   int wait_q = 0;
   logic slow_q = 1'b0;
   initial begin
      l1_ack_o = 1'b0;
      l1_rdata_o = '0;
   end
   // alternates prompt and slow answers; data scrambles outside the read ack cycle
   always @(posedge clk_i) begin
      l1_ack_o <= 1'b0;
      l1_rdata_o <= ~l1_rdata_o;
      if (l1_i.req && !l1_ack_o) begin
         if (wait_q < (slow_q ? 3 : 0)) begin
            wait_q <= wait_q + 1;
         end else begin
            wait_q <= 0;
            slow_q <= !slow_q;
            l1_ack_o <= 1'b1;
            for (int w = 0; w < 4; w++) begin
               if (l1_i.we && l1_i.wmask[w]) begin
                  mem_q[l1_i.idx][w*32 +: 32] <= l1_i.wdata[w*32 +: 32];
               end
            end
            if (!l1_i.we) begin
               l1_rdata_o <= mem_q[l1_i.idx];
            end
         end
      end
   end
endmodule // gsd_l1_model

`default_nettype wire

// File: test/gsd_top_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "gsd_regs.svh"

module gsd_top_bench;
   import gsd_pkg::*;
   // ----------------------------------------
   // stimulus and observed signals
   // ----------------------------------------
   logic clk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic cfg_we_i = 1'b0;
   logic [7:0] cfg_wdata_i = 8'h00;
   logic mem_valid_i = 1'b0;
   logic [31:0] mem_addr_i = 32'h0;
   logic [7:0] l1_line_i = 8'h00;
   gsd_creg_req_t creg_i = '0;
   logic blt_valid_i = 1'b0;
   gsd_blt_req_t blt_i = '0;
   logic [1:0] blt_reload_i = 2'b00;
   logic [7:0] cfg_rdata_o;
   logic gfx_insn_en_o, sp_tag_lock_o, l1_keep_o, creg_rvalid_o, l1_ack_i;
   logic blt_ready_o, blt_ack_o, blt_rvalid_o;
   logic [8:0] sp_lines_o, cache_lines_o;
   logic [31:0] creg_rdata_o, blt_rdata_o;
   logic [11:0] blt_addr_o;
   logic [127:0] l1_rdata_i;
   gsd_dec_t dec_o;
   gsd_l1_req_t l1_o;
   int miscompares = 0;
   int comparisons = 0;

   always #5 clk_i = ~clk_i;

   gsd_top dut (.clk_i(clk_i), .resetn_i(resetn_i), .cfg_we_i(cfg_we_i),
      .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o), .gfx_insn_en_o(gfx_insn_en_o),
      .sp_tag_lock_o(sp_tag_lock_o), .sp_lines_o(sp_lines_o), .cache_lines_o(cache_lines_o),
      .mem_valid_i(mem_valid_i), .mem_addr_i(mem_addr_i), .dec_o(dec_o),
      .l1_line_i(l1_line_i), .l1_keep_o(l1_keep_o), .creg_i(creg_i),
      .creg_rdata_o(creg_rdata_o), .creg_rvalid_o(creg_rvalid_o), .blt_valid_i(blt_valid_i),
      .blt_i(blt_i), .blt_reload_i(blt_reload_i), .blt_ready_o(blt_ready_o),
      .blt_ack_o(blt_ack_o), .blt_addr_o(blt_addr_o), .blt_rvalid_o(blt_rvalid_o),
      .blt_rdata_o(blt_rdata_o), .l1_o(l1_o), .l1_ack_i(l1_ack_i), .l1_rdata_i(l1_rdata_i));

   gsd_l1_model l1 (.clk_i(clk_i), .l1_i(l1_o), .l1_ack_o(l1_ack_i), .l1_rdata_o(l1_rdata_i));

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic cfg_write(input logic [7:0] v);
      cfg_we_i = 1'b1;
      cfg_wdata_i = v;
      @(negedge clk_i);
      cfg_we_i = 1'b0;
      repeat (3) @(negedge clk_i);
   endtask

   task automatic dec(input logic [31:0] a, input gsd_rgn_t r);
      mem_valid_i = 1'b1;
      mem_addr_i = a;
      @(negedge clk_i);
      check(dec_o.valid, 1'b1);
      check(dec_o.rgn, r);
      check(dec_o.off, a[23:0]);
   endtask

   // reads compare against d; writes go through the special-instruction port
   task automatic creg(input logic we, input logic [31:0] a, input logic [31:0] d);
      creg_i = '{we: we, re: !we, addr: a, wdata: d};
      @(negedge clk_i);
      creg_i = '0;
      if (!we) begin
         check(creg_rvalid_o, 1'b1);
         check(creg_rdata_o, d);
      end
      @(negedge clk_i);
   endtask

   task automatic blt(input logic s, input logic w, input logic [31:0] d,
      input logic [11:0] a);
      int n;
      blt_valid_i = 1'b1;
      blt_i = '{sel: s, wr: w, wdata: d};
      n = 0;
      while (blt_ready_o !== 1'b1 && n < 50) begin
         @(negedge clk_i);
         n++;
      end
      @(negedge clk_i);
      blt_valid_i = 1'b0;
      while (blt_ack_o !== 1'b1 && n < 100) begin
         @(negedge clk_i);
         n++;
      end
      check(blt_ack_o, 1'b1);
      check(blt_addr_o, a);
      if (!w) begin
         check(blt_rvalid_o, 1'b1);
         check(blt_rdata_o, d);
      end
      @(negedge clk_i);
   endtask

   task automatic reload(input logic [1:0] b);
      blt_reload_i = b;
      @(negedge clk_i);
      blt_reload_i = 2'b00;
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic test_reset();
      check(cfg_rdata_o, 8'h00);
      check(sp_tag_lock_o, 1'b0);
      check(cache_lines_o, 9'h100);
      check(blt_ready_o, 1'b1);
   endtask

   task automatic test_config();
      logic [8:0] lines;
      logic [7:0] ln;
      for (int k = 0; k < 4; k++) begin
         lines = (k == 0) ? 9'h000 : (k == 1) ? 9'h080 : (k == 2) ? 9'h0c0 : 9'h100;
         cfg_write(8'hf1 | 8'(k << 2));
         check(cfg_rdata_o, 8'h01 | 8'(k << 2));
         check(sp_lines_o, lines);
         check(cache_lines_o, 9'h100 - lines);
         check(sp_tag_lock_o, k != 0);
         check(gfx_insn_en_o, k != 0);
         for (int j = 0; j < 4; j++) begin
            ln = (j < 2 ? 8'h3f : 8'h7f) + 8'(j % 2);
            l1_line_i = ln;
            @(negedge clk_i);
            check(l1_keep_o, lines != 0 && {1'b0, ln} >= 9'h100 - lines);
         end
      end
   endtask

   task automatic test_decode();
      cfg_write(8'h0d);
      dec(32'h40007fff, GSD_RGN_SCRATCH);
      dec(32'h40008000, GSD_RGN_BIU);
      dec(32'h400080ff, GSD_RGN_BIU);
      dec(32'h40008100, GSD_RGN_GP);
      dec(32'h400082ff, GSD_RGN_GP);
      dec(32'h40008300, GSD_RGN_DC);
      dec(32'h40008400, GSD_RGN_MC);
      dec(32'h400084ff, GSD_RGN_MC);
      dec(32'h40008500, GSD_RGN_PM);
      dec(32'h40008fff, GSD_RGN_PM);
      dec(32'h40009000, GSD_RGN_NONE);
      dec(32'h4000ffff, GSD_RGN_NONE);
      dec(32'h40800000, GSD_RGN_GMEM);
      // next scan line at the 1024 and 2048 byte strides
      dec(32'h40800400, GSD_RGN_GMEM);
      dec(32'h40800800, GSD_RGN_GMEM);
      dec(32'h40bfffff, GSD_RGN_GMEM);
      dec(32'h40c00000, GSD_RGN_NONE);
      dec(32'h80008000, GSD_RGN_NONE);
      for (int g = 0; g < 4; g++) begin
         cfg_write(8'h0c | 8'(g));
         dec({2'(g), 30'h8100}, g == 0 ? GSD_RGN_NONE : GSD_RGN_GP);
      end
      mem_valid_i = 1'b0;
      cfg_write(8'h0d);
   endtask

   // size is set before any buffer register use or stream traffic
   task automatic test_creg();
      creg(1'b1, `GSD_CREG_START0, 32'h120);
      creg(1'b1, `GSD_CREG_START1, 32'h504);
      creg(1'b1, `GSD_CREG_CURSOR0, 32'h7f0);
      creg(1'b1, `GSD_CREG_CURSOR1, 32'h3a0);
      creg(1'b0, `GSD_CREG_START0, 32'h120);
      creg(1'b0, `GSD_CREG_START1, 32'h504);
      creg(1'b0, `GSD_CREG_CURSOR0, 32'h7f0);
      creg(1'b0, `GSD_CREG_CURSOR1, 32'h3a0);
      creg(1'b1, 32'hffffff4c, 32'h55);
      creg(1'b0, 32'hffffff4c, 32'h0);
   endtask

   task automatic test_stream();
      reload(2'b01);
      for (int i = 0; i < 5; i++) begin
         blt(1'b0, 1'b1, 32'ha0000000 + i, 12'h120 + 12'(4 * i));
      end
      creg(1'b0, `GSD_CREG_CURSOR0, 32'h130);
      creg(1'b0, `GSD_CREG_CURSOR1, 32'h3a0);
      reload(2'b10);
      blt(1'b1, 1'b1, 32'h000000b1, 12'h504);
      creg(1'b0, `GSD_CREG_CURSOR0, 32'h130);
      reload(2'b11);
      creg(1'b0, `GSD_CREG_CURSOR1, 32'h500);
      for (int i = 0; i < 5; i++) begin
         blt(1'b0, 1'b0, 32'ha0000000 + i, 12'h120 + 12'(4 * i));
      end
      blt(1'b1, 1'b0, 32'h000000b1, 12'h504);
   endtask

   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (2) @(negedge clk_i);
      resetn_i = 1'b1;
      @(negedge clk_i);
      test_reset();
      test_config();
      test_decode();
      test_creg();
      test_stream();
      complete_run();
   end

   initial begin
      #100us;
      miscompares++;
      complete_run();
   end
endmodule // gsd_top_bench

`default_nettype wire
